// ===== pkg/lrs_pkg.sv
// Purpose: constants for the four-channel line receiver status and transmit control block
// Assumes: APB register access, one 50 MHz clock
// Notes:   counts are in line bit periods, transmit clock periods or reference clock edges
package lrs_pkg;
    localparam int          NCH          = 4;
    localparam logic [11:0] ADDR_CTRL0   = 12'h000;
    localparam logic [11:0] ADDR_STAT0   = 12'h010;
    localparam logic [11:0] ADDR_STRIDE  = 12'h004;
    // control register fields
    localparam int          C_SINGLE     = 0;
    localparam int          C_TXEN       = 1;
    localparam int          C_EQ         = 2;
    localparam int          C_GAIN       = 3;
    localparam int          C_SELF       = 4;
    localparam int          C_ADIS       = 5;
    localparam int          C_DDIS       = 6;
    localparam int          C_MUTE       = 7;
    localparam int          C_IRQEN      = 8;
    localparam int          C_E3         = 9;
    localparam int          CW           = 10;
    localparam logic [9:0]  CTRL_RST     = 10'h000;
    // status register fields
    localparam int          S_LOL        = 0;
    localparam int          S_DIG        = 1;
    localparam int          S_ANA        = 2;
    localparam int          S_ALL        = 3;
    localparam int          S_FAULT      = 4;
    localparam int          S_STICKY     = 5;
    localparam int          SW           = 6;
    // counts
    localparam logic [7:0]  ZERO_RUN_LOS = 8'hAF;  // 175 zeros
    localparam logic [7:0]  DENS_PULSES  = 8'hAF;  // 175 pulses
    localparam logic [9:0]  DENS_BITS    = 10'h20D; // 525 bits, 33 % of it is 175
    localparam logic [7:0]  E3_LOS_BITS  = 8'hAF;  // 175 bit periods
    localparam logic [7:0]  DRIVE_IDLE   = 8'h80;  // 128 transmit clock periods
    localparam logic [9:0]  LOCK_WIN     = 10'h3FF; // 1024 reference edges
    localparam logic [10:0] LOCK_TOL     = 11'h005; // 0.5 % of 1024, rounded down
    localparam logic [2:0]  B3ZS_ZEROS   = 3'h3;
    localparam logic [2:0]  HDB3_ZEROS   = 3'h4;
    typedef enum logic {LRS_SIG_OK = 1'b0, LRS_SIG_LOST = 1'b1} lrs_los_t;
endpackage : lrs_pkg

// ===== src/lrs_top.sv
// Purpose: per-channel transmit control, drive monitor, line decoder and loss detection
// Assumes: all pins synchronous to pclk; bit periods marked by enable pulses
// Notes:   registers reached over APB, zero wait states
`timescale 1ns/10ps
`default_nettype none
module lrs_top
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_mode,
    input  wire logic [3:0]  transmitter_on,
    input  wire logic [3:0]  equalizer_in_select,
    input  wire logic [3:0]  receive_monitor_gain,
    input  wire logic [3:0]  loss_mute_enable,
    input  wire logic [3:0]  transmit_clock_in,
    input  wire logic [3:0]  tx_data_pos,
    input  wire logic [3:0]  tx_data_neg,
    output logic      [3:0]  line_tx_pos,
    output logic      [3:0]  line_tx_neg,
    output logic      [3:0]  line_tx_oe,
    input  wire logic [3:0]  monitor_pos_input,
    input  wire logic [3:0]  monitor_neg_input,
    output logic      [3:0]  drive_fault_out,
    output logic             drive_fault_irq,
    output logic      [3:0]  equalizer_in,
    output logic      [3:0]  monitor_gain_on,
    input  wire logic [3:0]  line_rx_bit_en,
    input  wire logic [3:0]  line_rx_pos,
    input  wire logic [3:0]  line_rx_neg,
    input  wire logic [3:0]  analog_below_threshold,
    input  wire logic [3:0]  reference_clock_in,
    input  wire logic [3:0]  recovered_clock_in,
    output logic      [3:0]  recovered_clock_out,
    output logic      [3:0]  lock_loss_flag,
    output logic      [3:0]  rx_data_pos,
    output logic      [3:0]  rx_data_neg,
    output logic      [3:0]  code_violation_pulse,
    output logic      [3:0]  combined_signal_loss
);
    function automatic logic [11:0] reg_addr(input logic [11:0] base, input int ch);
        reg_addr = base + 12'(ch) * lrs_pkg::ADDR_STRIDE;
    endfunction : reg_addr

    logic [lrs_pkg::CW-1:0] ctrl_reg [4];
    logic [lrs_pkg::SW-1:0] stat_w   [4];
    logic [31:0]            prdata_reg;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic [3:0]             sticky_irq;
    logic                   irq_reg;

    wire setup_ph  = psel & ~penable;
    wire access_ph = psel & penable & pready_reg;
    wire wr_done   = access_ph & pwrite;
    wire rd_done   = access_ph & ~pwrite;

    logic [31:0] rd_val;
    logic        addr_hit;
    always_comb
    begin
        rd_val   = 32'h0000_0000;
        addr_hit = 1'b0;
        for (int c = 0; c < lrs_pkg::NCH; c++)
        begin
            if (paddr == reg_addr(lrs_pkg::ADDR_CTRL0, c))
            begin
                rd_val   = {22'h00_0000, ctrl_reg[c]};
                addr_hit = 1'b1;
            end
            else if (paddr == reg_addr(lrs_pkg::ADDR_STAT0, c))
            begin
                rd_val   = {26'h000_0000, stat_w[c]};
                addr_hit = 1'b1;
            end
        end
    end

    // single cycle access phase; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup_ph;
            prdata_reg  <= setup_ph ? rd_val : prdata_reg;
            pslverr_reg <= setup_ph & ~addr_hit;
            irq_reg     <= |sticky_irq;
        end
    end
    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign drive_fault_irq = irq_reg;

    for (genvar c = 0; c < lrs_pkg::NCH; c++)
    begin : g_ch
        logic [lrs_pkg::CW-1:0] ctrl;
        logic        tx_pos_reg, tx_neg_reg, tx_oe_reg;
        logic [7:0]  idle_reg;
        logic        fault_reg, sticky_reg;
        logic        eq_reg, gain_reg;
        logic [7:0]  zrun_reg;
        logic        pol_reg;
        logic [3:0]  dl_reg;
        logic        lcv_reg, rxp_reg, rxn_reg;
        lrs_pkg::lrs_los_t dlst_reg, e3los_reg;
        logic [7:0]  pcnt_reg, e3cnt_reg;
        logic [9:0]  bcnt_reg;
        logic        ref_d_reg, rec_d_reg, freq_bad_reg, lol_reg, rclk_reg, rlst_reg;
        logic [9:0]  refcnt_reg;
        logic [10:0] reccnt_reg;

        assign ctrl = ctrl_reg[c];
        wire ctrl_wr  = wr_done & (paddr == reg_addr(lrs_pkg::ADDR_CTRL0, c));
        wire stat_rd  = rd_done & (paddr == reg_addr(lrs_pkg::ADDR_STAT0, c));

        // transmit enable: host mode gates the pin with the register bit; otherwise the pin alone
        wire tx_en    = host_mode ? (ctrl[lrs_pkg::C_TXEN] & transmitter_on[c])
                                  : transmitter_on[c];
        wire eq_eff   = host_mode ? ctrl[lrs_pkg::C_EQ] : equalizer_in_select[c];
        wire gain_eff = host_mode ? ctrl[lrs_pkg::C_GAIN] : receive_monitor_gain[c];
        wire mute_eff = host_mode ? ctrl[lrs_pkg::C_MUTE] : loss_mute_enable[c];
        wire tx_tick  = transmit_clock_in[c];

        // monitor source; transmit path never looks at it
        wire mon_mark = ctrl[lrs_pkg::C_SELF] ? (tx_pos_reg | tx_neg_reg)
                                              : (monitor_pos_input[c] | monitor_neg_input[c]);
        wire idle_hit = tx_tick & ~mon_mark & (idle_reg == lrs_pkg::DRIVE_IDLE - 8'h01);

        // receive decode
        wire         rx_tick  = line_rx_bit_en[c];
        wire         rp       = line_rx_pos[c];
        wire         rn       = line_rx_neg[c];
        wire         mark     = rp | rn;
        wire         single   = ctrl[lrs_pkg::C_SINGLE];
        wire         e3       = ctrl[lrs_pkg::C_E3];
        wire [2:0]   nz       = e3 ? lrs_pkg::HDB3_ZEROS : lrs_pkg::B3ZS_ZEROS;
        wire [7:0]   nz8      = {5'h00, nz};
        wire         same_pol = mark & ~(rp & rn) & (rp == pol_reg);
        wire         sub_00v  = same_pol & (zrun_reg == nz8 - 8'h01);
        wire         sub_b0v  = same_pol & (zrun_reg == nz8 - 8'h02);
        wire         legit    = sub_00v | sub_b0v;
        wire         bpv      = mark & ((rp & rn) | (same_pol & ~legit));
        wire         zrun_viol = ~mark & (zrun_reg + 8'h01 == nz8);
        wire [3:0]   dl_shift = {dl_reg[2:0], mark & ~legit};
        // a B0V/B00V removes the stuffed B still waiting in the line
        wire [3:0]   dl_mask  = sub_b0v ? (4'h1 << (nz - 3'h1)) : 4'h0;
        wire [7:0]   zrun_inc = (zrun_reg == 8'hFF) ? zrun_reg : zrun_reg + 8'h01;

        // loss detection
        wire         los_off  = ctrl[lrs_pkg::C_ADIS] & ctrl[lrs_pkg::C_DDIS];
        wire         dlst_set = ~mark & (zrun_reg + 8'h01 >= lrs_pkg::ZERO_RUN_LOS);
        wire         dens_end = mark & (pcnt_reg + 8'h01 == lrs_pkg::DENS_PULSES);
        wire         dens_ok  = dens_end & (bcnt_reg + 10'h001 < lrs_pkg::DENS_BITS);
        wire         dens_rst = dens_end | (bcnt_reg + 10'h001 >= lrs_pkg::DENS_BITS);
        wire         e3_low   = analog_below_threshold[c];
        wire         e3_diff  = e3_low != (e3los_reg == lrs_pkg::LRS_SIG_LOST);
        wire         dlst_v   = ~los_off & ~e3 & (dlst_reg == lrs_pkg::LRS_SIG_LOST);
        wire         alst_v   = ~los_off & (e3 ? (e3los_reg == lrs_pkg::LRS_SIG_LOST)
                                               : analog_below_threshold[c]);
        wire         rlst_v   = dlst_v | alst_v;

        // lock monitor counts edges of both clocks over a reference window
        wire         ref_edge = reference_clock_in[c] & ~ref_d_reg;
        wire         rec_edge = recovered_clock_in[c] & ~rec_d_reg;
        wire         win_end  = ref_edge & (refcnt_reg == lrs_pkg::LOCK_WIN);
        wire [10:0]  ref_n    = {1'b0, refcnt_reg} + 11'h001;
        wire [10:0]  diff     = (reccnt_reg > ref_n) ? reccnt_reg - ref_n : ref_n - reccnt_reg;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                ctrl_reg[c] <= lrs_pkg::CTRL_RST;
            else if (ctrl_wr)
                ctrl_reg[c] <= pwdata[lrs_pkg::CW-1:0];
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                tx_pos_reg <= 1'b0;
                tx_neg_reg <= 1'b0;
                tx_oe_reg  <= 1'b0;
                idle_reg   <= 8'h00;
                fault_reg  <= 1'b0;
                sticky_reg <= 1'b0;
                eq_reg     <= 1'b0;
                gain_reg   <= 1'b0;
            end
            else
            begin
                tx_oe_reg  <= tx_en;
                if (tx_tick)
                begin
                    tx_pos_reg <= tx_data_pos[c];
                    tx_neg_reg <= tx_data_neg[c];
                    if (mon_mark)
                        idle_reg <= 8'h00;
                    else if (idle_reg != lrs_pkg::DRIVE_IDLE)
                        idle_reg <= idle_reg + 8'h01;
                end
                fault_reg  <= (idle_reg == lrs_pkg::DRIVE_IDLE) | idle_hit;
                // a new fault beats the read that clears it
                sticky_reg <= idle_hit | (sticky_reg & ~stat_rd);
                eq_reg     <= eq_eff;
                gain_reg   <= gain_eff;
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                zrun_reg <= 8'h00;
                pol_reg  <= 1'b0;
                dl_reg   <= 4'h0;
                lcv_reg  <= 1'b0;
                rxp_reg  <= 1'b0;
                rxn_reg  <= 1'b0;
            end
            else
            begin
                lcv_reg <= rx_tick & ~single & (bpv | zrun_viol);
                if (rx_tick)
                begin
                    zrun_reg <= mark ? 8'h00 : zrun_inc;
                    pol_reg  <= mark ? rp : pol_reg;
                    dl_reg   <= dl_shift & ~dl_mask;
                    // muting wins over both bypass and decoded paths
                    rxp_reg  <= ~(rlst_reg & mute_eff) & (single ? rp : dl_reg[3]);
                    rxn_reg  <= ~(rlst_reg & mute_eff) & single & rn;
                end
                else if (rlst_reg & mute_eff)
                begin
                    rxp_reg  <= 1'b0;
                    rxn_reg  <= 1'b0;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                dlst_reg  <= lrs_pkg::LRS_SIG_OK;
                e3los_reg <= lrs_pkg::LRS_SIG_OK;
                pcnt_reg  <= 8'h00;
                bcnt_reg  <= 10'h000;
                e3cnt_reg <= 8'h00;
                rlst_reg  <= 1'b0;
            end
            else
            begin
                rlst_reg <= rlst_v;
                if (rx_tick)
                begin
                    case (dlst_reg)
                        lrs_pkg::LRS_SIG_OK:
                        begin
                            pcnt_reg <= 8'h00;
                            bcnt_reg <= 10'h000;
                            if (dlst_set)
                                dlst_reg <= lrs_pkg::LRS_SIG_LOST;
                        end
                        default:
                        begin
                            pcnt_reg <= dens_rst ? 8'h00 : pcnt_reg + {7'h00, mark};
                            bcnt_reg <= dens_rst ? 10'h000 : bcnt_reg + 10'h001;
                            if (dens_ok)
                                dlst_reg <= lrs_pkg::LRS_SIG_OK;
                        end
                    endcase
                    // 175 steady periods both ways, inside the 10 to 255 bound
                    if (!e3_diff)
                        e3cnt_reg <= 8'h00;
                    else if (e3cnt_reg + 8'h01 == lrs_pkg::E3_LOS_BITS)
                    begin
                        e3cnt_reg <= 8'h00;
                        e3los_reg <= e3_low ? lrs_pkg::LRS_SIG_LOST : lrs_pkg::LRS_SIG_OK;
                    end
                    else
                        e3cnt_reg <= e3cnt_reg + 8'h01;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ref_d_reg    <= 1'b0;
                rec_d_reg    <= 1'b0;
                refcnt_reg   <= 10'h000;
                reccnt_reg   <= 11'h000;
                freq_bad_reg <= 1'b1;
                lol_reg      <= 1'b1;
                rclk_reg     <= 1'b0;
            end
            else
            begin
                ref_d_reg  <= reference_clock_in[c];
                rec_d_reg  <= recovered_clock_in[c];
                refcnt_reg <= win_end ? 10'h000 : refcnt_reg + {9'h000, ref_edge};
                reccnt_reg <= win_end ? 11'h000 : reccnt_reg + {10'h000, rec_edge};
                if (win_end)
                    freq_bad_reg <= diff > lrs_pkg::LOCK_TOL;
                lol_reg    <= freq_bad_reg | rlst_v;
                // level select only; a real clock mux would be glitch-safe
                rclk_reg   <= lol_reg ? reference_clock_in[c] : recovered_clock_in[c];
            end
        end

        assign sticky_irq[c]           = sticky_reg & ctrl[lrs_pkg::C_IRQEN];
        assign stat_w[c]               = {sticky_reg, fault_reg, rlst_reg, alst_v, dlst_v, lol_reg};
        assign line_tx_pos[c]          = tx_pos_reg;
        assign line_tx_neg[c]          = tx_neg_reg;
        assign line_tx_oe[c]           = tx_oe_reg;
        assign drive_fault_out[c]      = fault_reg;
        assign equalizer_in[c]         = eq_reg;
        assign monitor_gain_on[c]      = gain_reg;
        assign recovered_clock_out[c]  = rclk_reg;
        assign lock_loss_flag[c]       = lol_reg;
        assign rx_data_pos[c]          = rxp_reg;
        assign rx_data_neg[c]          = rxn_reg;
        assign code_violation_pulse[c] = lcv_reg;
        assign combined_signal_loss[c] = rlst_reg;
    end
endmodule : lrs_top
`default_nettype wire

// ===== verification/line_receiver_status_and_tx_control_tb.sv
// Purpose: self-checking bench for lrs_top through APB and pins
// Assumes: line model gives one bit per four pclk cycles
// Notes:   counts kept exact, waits sized from them with margin
`timescale 1ns/10ps
`default_nettype none
module line_receiver_status_and_tx_control_tb;
    localparam logic [11:0] CT0 = lrs_pkg::ADDR_CTRL0;
    localparam logic [11:0] CT1 = lrs_pkg::ADDR_CTRL0 + lrs_pkg::ADDR_STRIDE;
    localparam logic [11:0] ST0 = lrs_pkg::ADDR_STAT0;
    localparam logic [11:0] ST1 = lrs_pkg::ADDR_STAT0 + lrs_pkg::ADDR_STRIDE;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        host_mode = 1'b1;
    logic [3:0]  transmitter_on = 4'h0;
    logic [3:0]  equalizer_in_select = 4'h0;
    logic [3:0]  receive_monitor_gain = 4'h0;
    logic [3:0]  loss_mute_enable = 4'h0;
    logic [3:0]  analog_below_threshold = 4'h0;
    logic [1:0]  mode = 2'h0;
    logic        slow = 1'b0;
    logic [31:0] prdata, last_rd;
    logic        pready, pslverr, drive_fault_irq, last_err;
    logic [3:0]  line_rx_bit_en, line_rx_pos, line_rx_neg, transmit_clock_in, tx_data_pos;
    logic [3:0]  reference_clock_in, recovered_clock_in, line_tx_oe, drive_fault_out;
    logic [3:0]  equalizer_in, monitor_gain_on, lock_loss_flag;
    logic [3:0]  code_violation_pulse, combined_signal_loss;
    int          failures = 0;
    int          cmp_count = 0;
    int          viol0 = 0;
    int          viol1 = 0;
    int          v0, v1;
    lrs_line_model u_line (.pclk, .mode, .slow, .bit_en(line_rx_bit_en), .rx_pos(line_rx_pos),
        .rx_neg(line_rx_neg), .tx_en(transmit_clock_in), .tx_pos(tx_data_pos),
        .ref_clk(reference_clock_in), .rec_clk(recovered_clock_in));
    // monitor pins tied to zero, so only self-select can see transitions
    lrs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .host_mode, .transmitter_on, .equalizer_in_select, .receive_monitor_gain,
        .loss_mute_enable, .transmit_clock_in, .tx_data_pos, .tx_data_neg(4'h0),
        .line_tx_pos(), .line_tx_neg(), .line_tx_oe, .monitor_pos_input(4'h0),
        .monitor_neg_input(4'h0), .drive_fault_out, .drive_fault_irq, .equalizer_in,
        .monitor_gain_on, .line_rx_bit_en, .line_rx_pos, .line_rx_neg,
        .analog_below_threshold, .reference_clock_in, .recovered_clock_in,
        .recovered_clock_out(), .lock_loss_flag, .rx_data_pos(), .rx_data_neg(),
        .code_violation_pulse, .combined_signal_loss);
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk)
    begin
        viol0 <= viol0 + int'(code_violation_pulse[0]);
        viol1 <= viol1 + int'(code_violation_pulse[1]);
    end
    function automatic logic [31:0] bit_of(input int i);
        return 32'h1 << i;
    endfunction : bit_of
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // held from setup to the edge that sees pready, never released early
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        last_err = pslverr;
        last_rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(last_rd & m, e);
    endtask : rd
    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial
    begin
        tick(40000);
        failures++;
        $display("[FAIL] %0t run did not finish", $time);
        report_and_stop();
    end
    initial
    begin
        tick(3);
        presetn <= 1'b1;
        tick(1);
        rd(CT0, 32'hFFFFFFFF, 32'h0);
        rd(ST0, bit_of(lrs_pkg::S_LOL), bit_of(lrs_pkg::S_LOL));
        rd(12'h020, 32'hFFFFFFFF, 32'h0);
        check(32'(last_err), 32'h1);
        transmitter_on <= 4'hF;
        tick(4);
        check(32'(line_tx_oe), 32'h0);
        apb(1'b1, CT0, bit_of(lrs_pkg::C_TXEN));
        tick(4);
        check(32'(line_tx_oe), 32'h1);
        transmitter_on <= 4'hE;
        tick(4);
        check(32'(line_tx_oe), 32'h0);
        host_mode <= 1'b0;
        transmitter_on <= 4'hF;
        equalizer_in_select <= 4'hA;
        receive_monitor_gain <= 4'h5;
        loss_mute_enable <= 4'hF;
        apb(1'b1, CT0, bit_of(lrs_pkg::C_SELF));
        apb(1'b1, CT1, bit_of(lrs_pkg::C_IRQEN));
        check(32'(equalizer_in), 32'hA);
        check(32'(monitor_gain_on), 32'h5);
        tick(800);
        check(32'(drive_fault_out), 32'hE);
        check(32'(drive_fault_irq), 32'h1);
        apb(1'b1, CT1, bit_of(lrs_pkg::C_IRQEN) | bit_of(lrs_pkg::C_SELF));
        tick(20);
        rd(ST1, 32'h30, bit_of(lrs_pkg::S_STICKY));
        rd(ST1, 32'h30, 32'h0);
        apb(1'b1, CT1, bit_of(lrs_pkg::C_SINGLE));
        mode <= 2'h2;
        v0 = viol0;
        v1 = viol1;
        tick(100);
        check(32'(viol0 > v0), 32'h1);
        check(32'(viol1 - v1), 32'h0);
        apb(1'b1, CT1, bit_of(lrs_pkg::C_ADIS) | bit_of(lrs_pkg::C_DDIS));
        mode <= 2'h1;
        tick(8);
        v0 = viol0;
        tick(892);
        check(32'(viol0 > v0), 32'h1);
        check(32'(combined_signal_loss), 32'hD);
        rd(ST0, 32'hA, 32'hA);
        mode <= 2'h0;
        tick(2400);
        check(32'(combined_signal_loss), 32'h0);
        tick(5000);
        check(32'(lock_loss_flag), 32'h0);
        slow <= 1'b1;
        tick(5000);
        check(32'(lock_loss_flag), 32'hF);
        slow <= 1'b0;
        apb(1'b1, CT1, bit_of(lrs_pkg::C_E3));
        analog_below_threshold <= 4'h3;
        tick(20);
        rd(ST0, 32'hC, 32'hC);
        rd(ST1, 32'h4, 32'h0);
        tick(1000);
        rd(ST1, 32'h4, 32'h4);
        analog_below_threshold <= 4'h0;
        tick(1100);
        rd(ST1, 32'h4, 32'h0);
        report_and_stop();
    end
endmodule : line_receiver_status_and_tx_control_tb
`default_nettype wire

// ===== verification/lrs_line_model.sv
// Purpose: far-side line and terminal model for lrs_top
// Assumes: one line bit and one transmit period every four pclk cycles
// Notes:   mode 0 alternate marks, 1 all zeros, 2 both rails; slow skews recovery
`timescale 1ns/10ps
`default_nettype none
module lrs_line_model
(
    input  wire logic       pclk,
    input  wire logic [1:0] mode,
    input  wire logic       slow,
    output logic      [3:0] bit_en,
    output logic      [3:0] rx_pos,
    output logic      [3:0] rx_neg,
    output logic      [3:0] tx_en,
    output logic      [3:0] tx_pos,
    output logic      [3:0] ref_clk,
    output logic      [3:0] rec_clk
);
    logic [1:0] ph = 2'h0;
    logic [1:0] p3 = 2'h0;
    logic       mark = 1'b0;
    always @(posedge pclk)
    begin
        ph <= ph + 2'h1;
        p3 <= (p3 == 2'h2) ? 2'h0 : p3 + 2'h1;
        bit_en <= {4{ph == 2'h0}};
        tx_en <= {4{ph == 2'h2}};
        ref_clk <= {4{ph[1]}};
        // slow recovery runs at three cycles, far beyond tolerance
        rec_clk <= slow ? {4{p3 == 2'h0}} : {4{ph[1]}};
        if (ph == 2'h0)
        begin
            mark <= ~mark;
            tx_pos <= {4{mark}};
            rx_pos <= {4{mode == 2'h2 || (mode == 2'h0 && !mark)}};
            rx_neg <= {4{mode == 2'h2 || (mode == 2'h0 && mark)}};
        end
    end
endmodule : lrs_line_model
`default_nettype wire

// ===== verification/lrs_top_assertions.sv
// Purpose: port-level assertions for lrs_top, channel 0 watched, all four for equalizer and gain
// Assumes: one pclk domain, registered outputs one edge behind their cause
// Notes:   channels are identical instances, so one channel stands for all
`timescale 1ns/10ps
`default_nettype none
module lrs_top_assertions
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       host_mode,
    input wire logic [3:0] transmitter_on,
    input wire logic [3:0] equalizer_in_select,
    input wire logic [3:0] receive_monitor_gain,
    input wire logic [3:0] loss_mute_enable,
    input wire logic [3:0] transmit_clock_in,
    input wire logic [3:0] tx_data_pos,
    input wire logic [3:0] line_tx_pos,
    input wire logic [3:0] line_tx_oe,
    input wire logic [3:0] equalizer_in,
    input wire logic [3:0] monitor_gain_on,
    input wire logic [3:0] line_rx_bit_en,
    input wire logic [3:0] reference_clock_in,
    input wire logic [3:0] recovered_clock_in,
    input wire logic [3:0] recovered_clock_out,
    input wire logic [3:0] lock_loss_flag,
    input wire logic [3:0] rx_data_pos,
    input wire logic [3:0] rx_data_neg,
    input wire logic [3:0] code_violation_pulse,
    input wire logic [3:0] combined_signal_loss
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_pin_off;
        !transmitter_on[0] [*3];
    endsequence
    sequence s_hw_on;
        (!host_mode && transmitter_on[0]) [*3];
    endsequence
    sequence s_muted_loss;
        (!host_mode && loss_mute_enable[0] && combined_signal_loss[0]) [*2];
    endsequence
    a_tx_off_tristate: assert property (s_pin_off |-> !line_tx_oe[0])
        else $error("transmit outputs driven with on pin low");
    a_hw_pin_on: assert property (s_hw_on |-> line_tx_oe[0])
        else $error("transmitter off with pin high in hardware mode");
    a_tx_data_path: assert property (transmit_clock_in[0] ##1 line_tx_oe[0]
        |-> line_tx_pos[0] == $past(tx_data_pos[0]))
        else $error("transmit data not passed to line");
    a_eq_follow_pin: assert property (!host_mode [*2]
        |-> equalizer_in == $past(equalizer_in_select))
        else $error("equalizer select not followed");
    a_gain_follow_pin: assert property (!host_mode [*2]
        |-> monitor_gain_on == $past(receive_monitor_gain))
        else $error("monitor gain not followed");
    a_viol_after_bit: assert property (code_violation_pulse[0]
        |-> $past(line_rx_bit_en[0]))
        else $error("violation pulse without a received bit");
    a_mute_zero_data: assert property (s_muted_loss |-> !rx_data_pos[0] && !rx_data_neg[0])
        else $error("receive data not muted during loss");
    a_lol_ref_clock: assert property (lock_loss_flag[0] [*2]
        |-> recovered_clock_out[0] == $past(reference_clock_in[0]))
        else $error("reference clock not output while unlocked");
    a_lock_rec_clock: assert property (!lock_loss_flag[0] [*2]
        |-> recovered_clock_out[0] == $past(recovered_clock_in[0]))
        else $error("recovered clock not output while locked");
endmodule : lrs_top_assertions
bind lrs_top lrs_top_assertions u_chk
(
    .pclk(pclk), .presetn(presetn), .host_mode(host_mode), .transmitter_on(transmitter_on),
    .equalizer_in_select(equalizer_in_select), .receive_monitor_gain(receive_monitor_gain),
    .loss_mute_enable(loss_mute_enable), .transmit_clock_in(transmit_clock_in),
    .tx_data_pos(tx_data_pos), .line_tx_pos(line_tx_pos), .line_tx_oe(line_tx_oe),
    .equalizer_in(equalizer_in), .monitor_gain_on(monitor_gain_on),
    .line_rx_bit_en(line_rx_bit_en), .reference_clock_in(reference_clock_in),
    .recovered_clock_in(recovered_clock_in), .recovered_clock_out(recovered_clock_out),
    .lock_loss_flag(lock_loss_flag), .rx_data_pos(rx_data_pos), .rx_data_neg(rx_data_neg),
    .code_violation_pulse(code_violation_pulse), .combined_signal_loss(combined_signal_loss)
);
`default_nettype wire
